// [hdl/pattern_seq_pkg.sv]
// Constants and types for the gray-scale and bar/dot pattern sequencer
package pattern_seq_pkg;

   // Register map: word index is the address, one word each
   localparam logic [3:0] ADDR_CTRL       = 4'h0;
   localparam logic [3:0] ADDR_STEP_PER   = 4'h1;
   localparam logic [3:0] ADDR_LEVEL_0    = 4'h2;
   localparam logic [3:0] ADDR_LEVEL_7    = 4'h9;
   localparam logic [3:0] ADDR_HSPACE     = 4'ha;
   localparam logic [3:0] ADDR_HPOS       = 4'hb;
   localparam logic [3:0] ADDR_VBAR_PER   = 4'hc;
   localparam logic [3:0] ADDR_VPOS       = 4'hd;
   localparam logic [3:0] ADDR_STATUS     = 4'he;

   // Control register field positions
   localparam int CTRL_MODE_LSB      = 0;
   localparam int CTRL_GRAY_EN_BIT   = 2;
   localparam int CTRL_BLACK_SEL_BIT = 3;

   // Reset values
   localparam logic [1:0]  MODE_RST      = 2'h0;
   localparam logic [15:0] STEP_PER_RST  = 16'h0040;
   localparam logic [15:0] HSPACE_RST    = 16'h0010;
   localparam logic [15:0] HPOS_RST      = 16'h0008;
   localparam logic [15:0] VBAR_PER_RST  = 16'h0020;
   localparam logic [15:0] VPOS_RST      = 16'h0010;
   localparam logic [7:0]  LEVEL_RST     = 8'h00;
   localparam logic [7:0]  BLACK_LEVEL   = 8'h00;
   localparam logic [7:0]  WHITE_LEVEL   = 8'hff;

   // Fixed width of the vertical-bar pulse, in clock cycles
   localparam logic [3:0]  VPULSE_CYCLES = 4'h2;

   typedef enum logic [1:0] {
      MODE_VBARS = 2'h0,
      MODE_BARS  = 2'h1,
      MODE_DOTS  = 2'h2,
      MODE_HBARS = 2'h3
   } bar_mode_type;

   // Black forced through blanking (default) or only during step 1
   typedef enum logic {
      BLACK_IN_BLANKING = 1'b0,
      BLACK_IN_STEP1    = 1'b1
   } black_sel_type;

   typedef struct packed {
      logic       line_gate;   // high during active line
      logic       h_blank;
      logic       v_blank;
      logic       line_start;  // one-cycle line-rate trigger
   } timing_in_type;

   typedef struct packed {
      logic [7:0] level;
      logic       black_hold;
      logic       gray_black;
   } video_out_type;

endpackage : pattern_seq_pkg

// [hdl/pattern_seq.sv]
// Gray-scale step sequencer and bar/dot pattern timing
// Notes on behaviour
// - Step clock held during line sync pulse, restarts from known phase after it.
// - Ring advances one stage per step clock tick.
// - A start flop loads the first ring position after the line reset.
// - First step after blanking is the leading, normally black, step.
// - Active stage selects its own one of eight programmable levels.
// - Next tick drops old stage level and picks next; one level at a time.
// - Ring cleared to initial state at each line end via inverted line gate.
// - Line-end reset sets black-hold latch forcing black output.
// - First ring step output clears the black-hold latch.
// - Option forces analog black through blanking or only during step one.
// - Horizontal element turns on at line start once spacing has expired.
// - Horizontal element lasts exactly one line, then forced off.
// - Spacing interval restarts after each horizontal element.
// - Spacing preset from position control during vertical blanking.
// - Vertical-bar oscillator runs in active line, held in blanking.
// - Start delay after blanking set by horizontal position control.
// - Each oscillator cycle fires a short fixed-width pulse.
// - V-bars mode: pulses every line, no horizontal elements.
// - Bar mode: pulses plus full-line on where horizontal element active.
// - Dots mode: pulses only on lines with horizontal element.
// - H-bars mode: all vertical pulses suppressed.
`timescale 1ns/1ps
module pattern_seq #(
   parameter int STAGES = 8,
   parameter int CW     = 16
) (
   input  wire logic                          core_clk_in,
   input  wire logic                          arst_n_in,
   input  wire pattern_seq_pkg::timing_in_type timing_in,
   input  wire logic [3:0]                    addr_in,
   input  wire logic [31:0]                   wdata_in,
   input  wire logic                          wr_in,
   input  wire logic                          rd_in,
   output logic [31:0]                        rdata_out,
   output logic [7:0]                         gray_level_out,
   output logic                               gray_black_out,
   output logic                               digital_black_out,
   output logic                               bar_pattern_out
);

   // Software-set controls
   logic [1:0]        mode_r;
   logic              gray_en_r;
   logic              black_sel_r;
   logic [CW-1:0]     step_per_r;
   logic [CW-1:0]     hspace_r;
   logic [CW-1:0]     hpos_r;
   logic [CW-1:0]     vbar_per_r;
   logic [CW-1:0]     vpos_r;
   logic [7:0]        level_r [STAGES];

   // Gray-scale state
   logic [CW-1:0]     step_cnt_r;
   logic              step_tick;
   logic              line_gate_d_r;
   logic              line_end;
   logic [STAGES-1:0] ring_r;
   logic              ring_start_flop_r;
   logic              black_hold_latch_r;
   logic              first_step_output;
   logic              line_reset_inverter;

   // Bar state
   logic [CW-1:0]     space_cnt_r;
   logic              hbar_r;
   logic [CW-1:0]     vosc_cnt_r;
   logic              vdelay_r;
   logic [3:0]        vpulse_cnt_r;
   logic              blanking;
   logic              vpulse;

   assign blanking            = timing_in.h_blank | timing_in.v_blank;
   assign line_reset_inverter = ~timing_in.line_gate;
   assign line_end            = line_gate_d_r & line_reset_inverter;
   assign first_step_output   = ring_r[0];
   assign vpulse              = (vpulse_cnt_r != 4'h0);

   // Control word: bar mode, gray enable, analog black placement
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         mode_r      <= pattern_seq_pkg::MODE_RST;
         gray_en_r   <= 1'b0;
         black_sel_r <= pattern_seq_pkg::BLACK_IN_BLANKING;
      end
      else if (wr_in && addr_in == pattern_seq_pkg::ADDR_CTRL)
      begin
         mode_r      <= wdata_in[pattern_seq_pkg::CTRL_MODE_LSB +: 2];
         gray_en_r   <= wdata_in[pattern_seq_pkg::CTRL_GRAY_EN_BIT];
         black_sel_r <= wdata_in[pattern_seq_pkg::CTRL_BLACK_SEL_BIT];
      end
   end

   // Step period in clock cycles
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         step_per_r <= pattern_seq_pkg::STEP_PER_RST;
      else if (wr_in && addr_in == pattern_seq_pkg::ADDR_STEP_PER)
         step_per_r <= wdata_in[CW-1:0];
   end

   // Spacing between horizontal elements, in lines
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         hspace_r <= pattern_seq_pkg::HSPACE_RST;
      else if (wr_in && addr_in == pattern_seq_pkg::ADDR_HSPACE)
         hspace_r <= wdata_in[CW-1:0];
   end

   // Horizontal position: delay from blanking to the first vertical pulse
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         hpos_r <= pattern_seq_pkg::HPOS_RST;
      else if (wr_in && addr_in == pattern_seq_pkg::ADDR_HPOS)
         hpos_r <= wdata_in[CW-1:0];
   end

   // Vertical-bar period in clock cycles
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         vbar_per_r <= pattern_seq_pkg::VBAR_PER_RST;
      else if (wr_in && addr_in == pattern_seq_pkg::ADDR_VBAR_PER)
         vbar_per_r <= wdata_in[CW-1:0];
   end

   // Vertical position: spacing preset taken during field blanking
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         vpos_r <= pattern_seq_pkg::VPOS_RST;
      else if (wr_in && addr_in == pattern_seq_pkg::ADDR_VPOS)
         vpos_r <= wdata_in[CW-1:0];
   end

   // Eight level presets, one per ring stage
   generate
      for (genvar i = 0; i < STAGES; i++)
      begin : g_level
         always_ff @(posedge core_clk_in or negedge arst_n_in)
         begin
            if (!arst_n_in)
               level_r[i] <= pattern_seq_pkg::LEVEL_RST;
            else if (wr_in && addr_in == pattern_seq_pkg::ADDR_LEVEL_0 + 4'(i))
               level_r[i] <= wdata_in[7:0];
         end
      end
   endgenerate

   // Read data, valid the cycle after the strobe only
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rdata_out <= 32'h0000_0000;
      else if (rd_in)
      begin
         rdata_out <= 32'h0000_0000;
         if (addr_in >= pattern_seq_pkg::ADDR_LEVEL_0
             && addr_in <= pattern_seq_pkg::ADDR_LEVEL_7)
            rdata_out[7:0] <= level_r[3'(addr_in - pattern_seq_pkg::ADDR_LEVEL_0)];
         else
         begin
            case (addr_in)
               pattern_seq_pkg::ADDR_CTRL:
                  rdata_out[3:0] <= {black_sel_r, gray_en_r, mode_r};
               pattern_seq_pkg::ADDR_STEP_PER: rdata_out[CW-1:0] <= step_per_r;
               pattern_seq_pkg::ADDR_HSPACE:   rdata_out[CW-1:0] <= hspace_r;
               pattern_seq_pkg::ADDR_HPOS:     rdata_out[CW-1:0] <= hpos_r;
               pattern_seq_pkg::ADDR_VBAR_PER: rdata_out[CW-1:0] <= vbar_per_r;
               pattern_seq_pkg::ADDR_VPOS:     rdata_out[CW-1:0] <= vpos_r;
               pattern_seq_pkg::ADDR_STATUS:
                  rdata_out[STAGES+3:0] <= {ring_r, vdelay_r, hbar_r,
                                           ring_start_flop_r, black_hold_latch_r};
               default: ;
            endcase
         end
      end
      else
         rdata_out <= 32'h0000_0000;
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         line_gate_d_r <= 1'b0;
      else
         line_gate_d_r <= timing_in.line_gate;
   end

   // Step clock divider; its count is held at zero outside the line gate so the
   // first tick lands a fixed time after the sync pulse ends
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         step_cnt_r <= '0;
         step_tick  <= 1'b0;
      end
      else if (!timing_in.line_gate)
      begin
         step_cnt_r <= '0;
         step_tick  <= 1'b0;
      end
      else if (step_cnt_r >= step_per_r - CW'(1))
      begin
         step_cnt_r <= '0;
         step_tick  <= 1'b1;
      end
      else
      begin
         step_cnt_r <= step_cnt_r + CW'(1);
         step_tick  <= 1'b0;
      end
   end

   // Ring counter with its start flop
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ring_r            <= '0;
         ring_start_flop_r <= 1'b1;
      end
      else if (line_reset_inverter)
      begin
         ring_r            <= '0;
         ring_start_flop_r <= 1'b1;
      end
      else if (step_tick)
      begin
         if (ring_start_flop_r)
         begin
            ring_r            <= STAGES'(1);
            ring_start_flop_r <= 1'b0;
         end
         else
            ring_r <= {ring_r[STAGES-2:0], 1'b0};
      end
   end

   // Black-hold latch: set by line end reset, cleared by first step
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         black_hold_latch_r <= 1'b1;
      else if (line_end)
         black_hold_latch_r <= 1'b1;
      else if (first_step_output)
         black_hold_latch_r <= 1'b0;
   end

   // Gray output: one-hot ring selects one preset, black while the ring is clear
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         gray_level_out <= pattern_seq_pkg::BLACK_LEVEL;
      else
      begin
         gray_level_out <= pattern_seq_pkg::BLACK_LEVEL;
         for (int i = 0; i < STAGES; i++)
            if (ring_r[i])
               gray_level_out <= level_r[i];
      end
   end

   // Digital black: held by the latch and through all blanking
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         digital_black_out <= 1'b1;
      else
         digital_black_out <= black_hold_latch_r | blanking;
   end

   // Analog black: through blanking, or only while the first stage is active
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         gray_black_out <= 1'b1;
      else if (black_sel_r == pattern_seq_pkg::BLACK_IN_STEP1)
         gray_black_out <= first_step_output;
      else
         gray_black_out <= blanking | ~timing_in.line_gate;
   end

   // Horizontal element and its spacing counter
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         space_cnt_r <= '0;
         hbar_r      <= 1'b0;
      end
      else if (timing_in.v_blank)
      begin
         space_cnt_r <= vpos_r;
         hbar_r      <= 1'b0;
      end
      else if (hbar_r && line_end)
      begin
         hbar_r      <= 1'b0;
         space_cnt_r <= hspace_r;
      end
      else if (timing_in.line_start && !hbar_r)
      begin
         if (space_cnt_r == '0)
            hbar_r <= 1'b1;
         else
            space_cnt_r <= space_cnt_r - CW'(1);
      end
   end

   // Vertical-bar oscillator: delay from blanking, then free run
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         vosc_cnt_r <= '0;
         vdelay_r   <= 1'b1;
      end
      else if (blanking)
      begin
         vosc_cnt_r <= hpos_r;
         vdelay_r   <= 1'b1;
      end
      else if (vosc_cnt_r == '0)
      begin
         vosc_cnt_r <= vbar_per_r - CW'(1);
         vdelay_r   <= 1'b0;
      end
      else
         vosc_cnt_r <= vosc_cnt_r - CW'(1);
   end

   // Fixed-width pulse per oscillator cycle; a new cycle restarts it
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         vpulse_cnt_r <= 4'h0;
      else if (blanking)
         vpulse_cnt_r <= 4'h0;
      else if (vosc_cnt_r == '0)
         vpulse_cnt_r <= pattern_seq_pkg::VPULSE_CYCLES;
      else if (vpulse_cnt_r != 4'h0)
         vpulse_cnt_r <= vpulse_cnt_r - 4'h1;
   end

   // Pattern mixing by mode
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         bar_pattern_out <= 1'b0;
      else if (blanking)
         bar_pattern_out <= 1'b0;
      else
      begin
         case (pattern_seq_pkg::bar_mode_type'(mode_r))
            pattern_seq_pkg::MODE_VBARS: bar_pattern_out <= vpulse;
            pattern_seq_pkg::MODE_BARS:  bar_pattern_out <= vpulse | hbar_r;
            pattern_seq_pkg::MODE_DOTS:  bar_pattern_out <= vpulse & hbar_r;
            pattern_seq_pkg::MODE_HBARS: bar_pattern_out <= hbar_r;
            default:                     bar_pattern_out <= 1'b0;
         endcase
      end
   end

endmodule : pattern_seq

// [verification/timing_source.sv]
// Line and field timing source standing in for the sync chain
`timescale 1ns/1ps
module timing_source #(
   parameter int LINE  = 200,
   parameter int BLK   = 20,
   parameter int LINES = 12,
   parameter int VB    = 2
) (
   input  wire logic                      core_clk_in,
   input  wire logic                      arst_n_in,
   output pattern_seq_pkg::timing_in_type timing_out
);
   int pix_r;
   int row_r;
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         pix_r <= 0;
         row_r <= 0;
      end
      else
      begin
         pix_r <= (pix_r == LINE - 1) ? 0 : pix_r + 1;
         if (pix_r == LINE - 1)
            row_r <= (row_r == LINES - 1) ? 0 : row_r + 1;
      end
   end
   // Blanking leads each line so the line gate falls at the line end
   assign timing_out.h_blank    = pix_r < BLK;
   assign timing_out.v_blank    = row_r < VB;
   assign timing_out.line_gate  = (pix_r >= BLK) && (row_r >= VB);
   assign timing_out.line_start = (pix_r == BLK) && (row_r >= VB);
endmodule : timing_source

// [verification/pattern_seq_checker.sv]
// Concurrent checks on the pattern sequencer ports
`timescale 1ns/1ps
module pattern_seq_checker (
   input wire logic                           core_clk_in,
   input wire logic                           arst_n_in,
   input wire pattern_seq_pkg::timing_in_type timing_in,
   input wire logic [3:0]                     addr_in,
   input wire logic [31:0]                    wdata_in,
   input wire logic                           wr_in,
   input wire logic                           rd_in,
   input wire logic [31:0]                    rdata_out,
   input wire logic [7:0]                     gray_level_out,
   input wire logic                           gray_black_out,
   input wire logic                           digital_black_out,
   input wire logic                           bar_pattern_out
);
   logic [1:0] mode_r;
   logic       sel_r;
   logic       blank;
   logic       vmode;
   logic       hmode;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   assign blank = timing_in.h_blank || timing_in.v_blank;
   assign vmode = (mode_r == pattern_seq_pkg::MODE_VBARS)
                  || (mode_r == pattern_seq_pkg::MODE_DOTS);
   assign hmode = (mode_r == pattern_seq_pkg::MODE_HBARS);
   // Control mirror, seen only through the write port
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         mode_r <= pattern_seq_pkg::MODE_RST;
         sel_r  <= 1'b0;
      end
      else if (wr_in && (addr_in == pattern_seq_pkg::ADDR_CTRL))
      begin
         mode_r <= wdata_in[1:0];
         sel_r  <= wdata_in[pattern_seq_pkg::CTRL_BLACK_SEL_BIT];
      end
   end
   sequence s_pulse;
      bar_pattern_out [*2] ##1 !bar_pattern_out;
   endsequence
   sequence s_head;
      (digital_black_out && (gray_level_out == 8'h00)) [*3];
   endsequence
   a_read_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data not zero outside a read answer");
   a_bar_blank: assert property (blank [*2] |-> !bar_pattern_out)
      else $error("bar pattern high in blanking");
   a_black_blank: assert property (blank [*2] |-> digital_black_out)
      else $error("digital black missing in blanking");
   a_gray_black: assert property ((blank && !sel_r) [*3] |-> gray_black_out)
      else $error("analog black missing in blanking");
   a_ring_clear: assert property (!timing_in.line_gate [*3] |-> gray_level_out == 8'h00)
      else $error("gray level not cleared after line end");
   a_line_head: assert property ($rose(timing_in.line_gate) |-> s_head)
      else $error("line does not start in black");
   a_pulse_width: assert property ($rose(bar_pattern_out) && vmode |->
      s_pulse or (##[0:2] !timing_in.line_gate))
      else $error("vertical pulse width wrong");
   a_hbar_only: assert property ($rose(bar_pattern_out) && hmode |->
      $past(timing_in.line_start, 1) || $past(timing_in.line_start, 2)
      || $past(timing_in.line_start, 3))
      else $error("bar output rose away from line start");
endmodule : pattern_seq_checker

bind pattern_seq pattern_seq_checker i_pattern_seq_checker (
   .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .timing_in(timing_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .gray_level_out(gray_level_out),
   .gray_black_out(gray_black_out), .digital_black_out(digital_black_out),
   .bar_pattern_out(bar_pattern_out));

// [verification/tb_pattern_seq.sv]
// Self-checking bench for the pattern sequencer
`timescale 1ns/1ps
module tb_pattern_seq;
   localparam int LINE = 200;
   localparam int N    = 10;
   logic                           core_clk_in;
   logic                           arst_n_in;
   pattern_seq_pkg::timing_in_type timing;
   logic [3:0]                     addr;
   logic [31:0]                    wdata;
   logic [31:0]                    rdata;
   logic                           wr;
   logic                           rd;
   logic [7:0]                     gray;
   logic                           gblack;
   logic                           dblack;
   logic                           bar;
   logic [7:0]                     seed;
   int                             err_count;
   int                             samples_checked;

   timing_source #(.LINE(LINE), .BLK(20), .LINES(N + 2), .VB(2)) i_timing_source (
      .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .timing_out(timing));
   pattern_seq i_pattern_seq (
      .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .timing_in(timing),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .gray_level_out(gray), .gray_black_out(gblack), .digital_black_out(dblack),
      .bar_pattern_out(bar));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic [31:0] rst_val(input int a);
      case (a)
         1: return {16'h0, pattern_seq_pkg::STEP_PER_RST};
         10: return {16'h0, pattern_seq_pkg::HSPACE_RST};
         11: return {16'h0, pattern_seq_pkg::HPOS_RST};
         12: return {16'h0, pattern_seq_pkg::VBAR_PER_RST};
         13: return {16'h0, pattern_seq_pkg::VPOS_RST};
         default: return {24'h0, pattern_seq_pkg::LEVEL_RST};
      endcase
   endfunction : rst_val
   // Margin of four cycles keeps the last pulse clear of the line end
   function automatic int exp_pulses(input int len, input int hpos, input int per);
      return (len - hpos - 4) / per + 1;
   endfunction : exp_pulses
   function automatic int exp_hlines(input int n, input int vpos, input int hs);
      int c;
      c = 0;
      for (int l = vpos; l < n; l += hs + 1)
         c++;
      return c;
   endfunction : exp_hlines

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk_in);
      wr    <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk_in);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   // Waits for line start (0) or field blanking (1), bounded by 16 lines
   task automatic wait_sig(input bit vb);
      for (int i = 0; i < 16 * LINE; i++)
      begin
         @(posedge core_clk_in);
         #1;
         if ((vb ? timing.v_blank : timing.line_start) === 1'b1)
            return;
      end
      err_count++;
      print_verdict();
   endtask : wait_sig
   task automatic gray_line(input logic sel);
      logic [7:0]  lev [8];
      logic [31:0] d;
      wr_reg(pattern_seq_pkg::ADDR_CTRL, {28'h0, sel, 3'h0});
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr(seed);
         lev[k] = seed;
         wr_reg(4'(pattern_seq_pkg::ADDR_LEVEL_0 + k), {24'h0, seed});
         rd_reg(4'(pattern_seq_pkg::ADDR_LEVEL_0 + k), d);
         chk("level reg", {24'h0, seed}, d);
      end
      wait_sig(0);
      // Sample mid-step, away from the tick edges
      for (int k = 0; k < 9; k++)
      begin
         repeat (k == 0 ? 8 : 16) @(posedge core_clk_in);
         #1;
         chk("gray level", k == 0 ? 32'h0 : {24'h0, lev[k - 1]}, {24'h0, gray});
         if (k < 2)
            chk("digital black", {31'h0, k == 0}, {31'h0, dblack});
         if (k == 1 && sel)
            chk("analog black", 32'h1, {31'h0, gblack});
         if (k == 2)
            chk("analog black", 32'h0, {31'h0, gblack});
      end
      $display("test gray line done");
   endtask : gray_line
   task automatic run_mode(input int m);
      int vp, hs, c, full, pul, h, np;
      seed = lfsr(seed);
      vp = seed[3:2];
      hs = seed[1:0];
      wait_sig(0);
      wait_sig(1);
      wr_reg(pattern_seq_pkg::ADDR_CTRL, 32'(m));
      wr_reg(pattern_seq_pkg::ADDR_VPOS, 32'(vp));
      wr_reg(pattern_seq_pkg::ADDR_HSPACE, 32'(hs));
      h = exp_hlines(N, vp, hs);
      np = exp_pulses(LINE - 20, 10, 40);
      full = 0;
      pul = 0;
      for (int l = 0; l < N; l++)
      begin
         wait_sig(0);
         c = 0;
         repeat (LINE - 2)
         begin
            @(posedge core_clk_in);
            #1;
            c += (bar === 1'b1);
         end
         if (c > LINE / 2)
            full++;
         else if (c == np * int'(pattern_seq_pkg::VPULSE_CYCLES))
            pul++;
      end
      chk("full lines", m[0] ? h : 0, full);
      chk("pulse lines", (m == 0) ? N : (m == 1) ? N - h : (m == 2) ? h : 0, pul);
      $display("test mode %0d done", m);
   endtask : run_mode

   initial
   begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end
   initial
   begin
      logic [31:0] d;
      arst_n_in = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      err_count = 0;
      samples_checked = 0;
      seed = 8'h57;
      repeat (5) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      for (int a = 1; a < 16; a++)
         if (a != 14)
         begin
            rd_reg(4'(a), d);
            chk("reset value", rst_val(a), d);
         end
      wr_reg(4'hf, 32'hffffffff);
      rd_reg(4'hf, d);
      chk("unmapped", 32'h0, d);
      $display("test registers done");
      wr_reg(pattern_seq_pkg::ADDR_STEP_PER, 32'h10);
      wr_reg(pattern_seq_pkg::ADDR_HPOS, 32'ha);
      wr_reg(pattern_seq_pkg::ADDR_VBAR_PER, 32'h28);
      gray_line(1'b0);
      gray_line(1'b1);
      for (int m = 0; m < 4; m++)
         run_mode(m);
      print_verdict();
   end
endmodule : tb_pattern_seq
